// >>> bench/tb.sv
// Purpose: self-checking bench for the supply detector configuration bank
// Assumes: APB slave that answers in its own time, 10 MHz reference clock
// Notes: detector inputs driven directly by the bench, no partner model
`default_nettype none
module tb import sfd_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================================
	// signals and tables
	logic clk, rst_n, psel, penable, pwrite, pin, pready, pslverr;
	logic fault, warn, rng, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] level;
	logic [1:0] hv_kind;
	logic [9:0] hv_filt;
	int n_mismatch = 0;
	int compares = 0;
	localparam logic [7:0] REG_IDX [8] = '{IDX_HV_CFG, IDX_HV_RANGE, IDX_AUX_OVTH,
		IDX_AUX_OVHY, IDX_AUX_UVTH, IDX_AUX_UVHY, IDX_AUX_CFG, IDX_AUX_FUNC};
	localparam logic [7:0] REG_RST [8] = '{8'h03, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
		8'h03, 8'h03};
	localparam logic [7:0] REG_MSK [8] = '{8'h1F, 8'h01, 8'hFF, 8'h1F, 8'hFF, 8'h1F,
		8'h1F, 8'h03};
	localparam int DLY_US [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
	// ==========================================================================
	// device under test
	sfd_cfg_bank i_sfd_cfg_bank (
		.I_REF_CLK(clk),
		.I_RST_N(rst_n),
		.I_PSEL(psel),
		.I_PENABLE(penable),
		.I_PWRITE(pwrite),
		.I_PADDR(paddr),
		.I_PWDATA(pwdata),
		.O_PRDATA(prdata),
		.O_PREADY(pready),
		.O_PSLVERR(pslverr),
		.I_AUX1_LEVEL(level),
		.I_AUX1_PIN(pin),
		.O_AUX1_FAULT(fault),
		.O_AUX1_WARN(warn),
		.O_HV_RANGE_HIGH(rng),
		.O_HV_TRIP_KIND(hv_kind),
		.O_HV_FILT_CYCLES(hv_filt),
		.O_IRQ(irq)
	);
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ==========================================================================
	// shared tasks
	task tally_and_finish;
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request held until the rising edge that samples pready high; data taken there
	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				n_mismatch++;
				tally_and_finish();
			end
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask
	task set_lvl(input logic [7:0] v);
		@(posedge clk);
		level <= v;
	endtask
	function automatic logic sel(input int w);
		return (w == 0) ? fault : (w == 1) ? warn : irq;
	endfunction
	task wait_sig(input int w, input logic exp, input int lim);
		int n;
		logic v;
		n = 0;
		v = ~exp;
		while (v !== exp && n < lim)
		begin
			@(negedge clk);
			v = sel(w);
			n++;
		end
		chk({31'h0, v}, {31'h0, exp});
		if (v !== exp)
			tally_and_finish();
	endtask
	// any cycle off the expected level within the span is reported
	task hold_sig(input int w, input logic exp, input int cyc);
		logic v;
		v = exp;
		repeat (cyc)
		begin
			@(negedge clk);
			if (sel(w) !== exp)
				v = sel(w);
		end
		chk({31'h0, v}, {31'h0, exp});
	endtask
	// ==========================================================================
	// scenarios
	task t_reset;
		chk({30'h0, hv_kind}, 32'h3);
		chk({31'h0, fault}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 8; i++)
			rd_chk(REG_IDX[i], {24'h0, REG_RST[i]});
	endtask
	task t_rw;
		logic [31:0] pat [2];
		pat = '{32'hFFFFFFFF, 32'h0000005A};
		for (int p = 0; p < 2; p++)
		begin
			for (int i = 0; i < 8; i++)
				apb(1'b1, REG_IDX[i], pat[p]);
			for (int i = 0; i < 8; i++)
				rd_chk(REG_IDX[i], {24'h0, pat[p][7:0] & REG_MSK[i]});
			@(negedge clk);
			chk({31'h0, rng}, {31'h0, pat[p][0]});
			chk({30'h0, hv_kind}, {30'h0, pat[p][1:0]});
		end
		apb(1'b1, 8'h30, 32'hFF);
		chk({31'h0, err}, 32'h1);
		rd_chk(8'h30, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task t_hv_filter;
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, IDX_HV_CFG, {27'h0, c[2:0], 2'h1});
			@(negedge clk);
			@(negedge clk);
			chk({22'h0, hv_filt}, 32'(DLY_US[c] * 10));
			chk({30'h0, hv_kind}, 32'h1);
		end
	endtask
	task t_over;
		apb(1'b1, IDX_AUX_FUNC, 32'h0);
		apb(1'b1, IDX_AUX_CFG, 32'h0);
		apb(1'b1, IDX_AUX_OVTH, 32'h80);
		apb(1'b1, IDX_AUX_OVHY, 32'h10);
		set_lvl(8'h90);
		wait_sig(0, 1'b1, 20);
		hold_sig(2, 1'b0, 5);
		rd_chk(IDX_IRQ_STATUS, 32'h5);
		apb(1'b1, IDX_IRQ_ENABLE, 32'h1);
		wait_sig(2, 1'b1, 5);
		set_lvl(8'h75);
		hold_sig(0, 1'b1, 30);
		set_lvl(8'h6F);
		wait_sig(0, 1'b0, 20);
		apb(1'b1, IDX_IRQ_CLEAR, 32'h1);
		rd_chk(IDX_IRQ_STATUS, 32'h4);
		wait_sig(2, 1'b0, 5);
		apb(1'b1, IDX_IRQ_CLEAR, 32'hF);
		rd_chk(IDX_IRQ_STATUS, 32'h0);
	endtask
	task t_under;
		apb(1'b1, IDX_AUX_CFG, 32'h2);
		apb(1'b1, IDX_AUX_UVTH, 32'h40);
		apb(1'b1, IDX_AUX_UVHY, 32'h08);
		set_lvl(8'h30);
		wait_sig(0, 1'b1, 20);
		set_lvl(8'h45);
		hold_sig(0, 1'b1, 30);
		set_lvl(8'h50);
		wait_sig(0, 1'b0, 20);
		apb(1'b1, IDX_AUX_CFG, 32'h1);
		set_lvl(8'h30);
		wait_sig(0, 1'b1, 20);
		set_lvl(8'h60);
		wait_sig(0, 1'b0, 20);
		set_lvl(8'h90);
		wait_sig(0, 1'b1, 20);
		apb(1'b1, IDX_AUX_CFG, 32'h3);
		wait_sig(0, 1'b0, 5);
		set_lvl(8'h30);
		hold_sig(0, 1'b0, 30);
		apb(1'b1, IDX_AUX_CFG, 32'h0);
		hold_sig(0, 1'b0, 30);
	endtask
	task t_func;
		set_lvl(8'h90);
		apb(1'b1, IDX_AUX_FUNC, 32'h1);
		wait_sig(0, 1'b0, 20);
		@(posedge clk);
		pin <= 1'b1;
		wait_sig(0, 1'b1, 20);
		apb(1'b1, IDX_AUX_FUNC, 32'h2);
		wait_sig(1, 1'b1, 20);
		chk({31'h0, fault}, 32'h1);
		rd_chk(IDX_IRQ_STATUS, 32'hF);
		@(posedge clk);
		pin <= 1'b0;
		wait_sig(0, 1'b0, 20);
		chk({31'h0, warn}, 32'h1);
		apb(1'b1, IDX_AUX_FUNC, 32'h3);
		wait_sig(1, 1'b0, 20);
		@(posedge clk);
		pin <= 1'b1;
		hold_sig(0, 1'b0, 10);
		apb(1'b0, IDX_AUX_LEVEL, 32'h0);
		chk(rd, 32'h3);
		@(posedge clk);
		pin <= 1'b0;
		repeat (5) @(posedge clk);
		apb(1'b0, IDX_AUX_LEVEL, 32'h0);
		chk(rd, 32'h2);
	endtask
	// code 1 is 50 cycles: the trip must not come early and must come soon after
	task t_filter;
		apb(1'b1, IDX_AUX_FUNC, 32'h0);
		apb(1'b1, IDX_AUX_CFG, 32'h4);
		set_lvl(8'h00);
		wait_sig(0, 1'b0, 100);
		set_lvl(8'h90);
		hold_sig(0, 1'b0, 45);
		wait_sig(0, 1'b1, 20);
	endtask
	// ==========================================================================
	// main sequence and watchdog
	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		level = 8'h00;
		pin = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_rw();
		t_hv_filter();
		t_over();
		t_under();
		t_func();
		t_filter();
		tally_and_finish();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire

// >>> rtl/aux_det_if.sv
// Purpose: carrier between the register bank and the auxiliary detector
// Assumes: single clock domain
// Notes: none
`default_nettype none
interface aux_det_if import sfd_cfg_pkg::*;;
	logic [7:0] over_th;
	logic [7:0] under_th;
	logic [4:0] over_hyst;
	logic [4:0] under_hyst;
	logic [2:0] filt;
	trip_kind_t kind;
	logic [7:0] level;
	logic high_trip;
	logic low_trip;
	modport ctrl(output over_th, under_th, over_hyst, under_hyst, filt, kind, level,
		input high_trip, low_trip);
	modport det(input over_th, under_th, over_hyst, under_hyst, filt, kind, level,
		output high_trip, low_trip);
endinterface
`default_nettype wire

// >>> rtl/sfd_cfg_bank.sv
// Purpose: APB register bank for the high-voltage and first auxiliary supply detectors
// Assumes: APB3 slave, 32-bit data, one wait state on every access
// Notes: the 8-bit level code is sampled through two flops and should change slowly
//
// Overview of operation
// - filter code selects 0 to 100 us delay
// - trip kind selects over, both, under, off
// - range bit one selects high 6.0-14.4 V range
// - aux over-threshold is 8-bit writable compare value
// - over-trip active lowers threshold by hysteresis
// - aux under-threshold is 8-bit writable compare value
// - under-trip active raises threshold by hysteresis
// - function 00 detector fault, 01 logic fault
// - function 10 logic fault, detector warning only
// - function 11 no fault, level still readable
//
// The APB slave port was chosen for this implementation.
`default_nettype none
module sfd_cfg_bank import sfd_cfg_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [7:0] I_AUX1_LEVEL,
	input wire logic I_AUX1_PIN,
	output logic O_AUX1_FAULT,
	output logic O_AUX1_WARN,
	output logic O_HV_RANGE_HIGH,
	output logic [1:0] O_HV_TRIP_KIND,
	output logic [9:0] O_HV_FILT_CYCLES,
	output logic O_IRQ
);
	logic [1:0] pin_sync_reg;
	logic [7:0] lvl_s1_reg;
	logic [7:0] lvl_s2_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [7:0] hv_cfg_reg;
	logic [7:0] hv_range_reg;
	logic [7:0] over_th_reg;
	logic [7:0] over_hy_reg;
	logic [7:0] under_th_reg;
	logic [7:0] under_hy_reg;
	logic [7:0] aux_cfg_reg;
	logic [7:0] aux_func_reg;
	logic [9:0] hv_cycles_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_en_reg;
	logic irq_reg;
	logic fault_reg;
	logic warn_reg;
	logic [1:0] trip_prev_reg;
	logic [7:0] idx;
	logic acc_first;
	logic wr_en;
	logic hit;
	logic [31:0] rd_next;
	logic fault_next;
	logic warn_next;
	logic sfd_trip;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	aux_det_if aux_bus();

	function automatic logic wr_hit(input logic en, input logic [7:0] at, input logic [7:0] want);
		return en && (at == want);
	endfunction

	// ==========================================================================
	// input synchronisers
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			pin_sync_reg <= 2'h0;
			lvl_s1_reg <= 8'h00;
			lvl_s2_reg <= 8'h00;
		end
		else
		begin
			pin_sync_reg <= {pin_sync_reg[0], I_AUX1_PIN};
			lvl_s1_reg <= I_AUX1_LEVEL;
			lvl_s2_reg <= lvl_s1_reg;
		end
	end

	// ==========================================================================
	// APB handshake: one wait state, data and error registered with ready
	assign idx = I_PADDR[IDX_MSB:IDX_LSB];
	assign acc_first = I_PSEL && I_PENABLE && !pready_reg;
	assign wr_en = I_PSEL && I_PENABLE && pready_reg && I_PWRITE && hit;

	always_comb
	begin
		rd_next = 32'h0000_0000;
		hit = 1'b1;
		case (idx)
			IDX_HV_CFG: rd_next[7:0] = hv_cfg_reg;
			IDX_HV_RANGE: rd_next[7:0] = hv_range_reg;
			IDX_AUX_OVTH: rd_next[7:0] = over_th_reg;
			IDX_AUX_OVHY: rd_next[7:0] = over_hy_reg;
			IDX_AUX_UVTH: rd_next[7:0] = under_th_reg;
			IDX_AUX_UVHY: rd_next[7:0] = under_hy_reg;
			IDX_AUX_CFG: rd_next[7:0] = aux_cfg_reg;
			IDX_AUX_FUNC: rd_next[7:0] = aux_func_reg;
			IDX_IRQ_STATUS: rd_next[IRQ_W-1:0] = irq_status_reg;
			IDX_IRQ_CLEAR: rd_next = 32'h0000_0000;
			IDX_IRQ_ENABLE: rd_next[IRQ_W-1:0] = irq_en_reg;
			// the pin level stays visible in every function mode
			IDX_AUX_LEVEL: rd_next[2:0] = {aux_bus.low_trip, aux_bus.high_trip,
				pin_sync_reg[1]};
			default: hit = 1'b0;
		endcase
		if (I_PADDR[ADDR_W-1:IDX_MSB+1] != 2'h0)
			hit = 1'b0;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= acc_first;
			if (acc_first)
			begin
				pslverr_reg <= !hit;
				prdata_reg <= I_PWRITE ? 32'h0000_0000 : rd_next;
			end
		end
	end
	assign O_PREADY = pready_reg;
	assign O_PSLVERR = pslverr_reg;
	assign O_PRDATA = prdata_reg;

	// ==========================================================================
	// configuration registers; unused bits are masked on write
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			hv_cfg_reg <= RST_CFG;
			hv_range_reg <= RST_ZERO;
			over_th_reg <= RST_OVTH;
			over_hy_reg <= RST_ZERO;
			under_th_reg <= RST_ZERO;
			under_hy_reg <= RST_ZERO;
			aux_cfg_reg <= RST_CFG;
			aux_func_reg <= RST_FUNC;
		end
		else
		begin
			if (wr_hit(wr_en, idx, IDX_HV_CFG))
				hv_cfg_reg <= I_PWDATA[7:0] & MASK_CFG;
			if (wr_hit(wr_en, idx, IDX_HV_RANGE))
				hv_range_reg <= I_PWDATA[7:0] & MASK_RANGE;
			if (wr_hit(wr_en, idx, IDX_AUX_OVTH))
				over_th_reg <= I_PWDATA[7:0];
			if (wr_hit(wr_en, idx, IDX_AUX_OVHY))
				over_hy_reg <= I_PWDATA[7:0] & MASK_HYST;
			if (wr_hit(wr_en, idx, IDX_AUX_UVTH))
				under_th_reg <= I_PWDATA[7:0];
			if (wr_hit(wr_en, idx, IDX_AUX_UVHY))
				under_hy_reg <= I_PWDATA[7:0] & MASK_HYST;
			if (wr_hit(wr_en, idx, IDX_AUX_CFG))
				aux_cfg_reg <= I_PWDATA[7:0] & MASK_CFG;
			if (wr_hit(wr_en, idx, IDX_AUX_FUNC))
				aux_func_reg <= I_PWDATA[7:0] & MASK_FUNC;
		end
	end

	// ==========================================================================
	// high-voltage detector settings driven out
	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			hv_cycles_reg <= 10'h000;
		else
			hv_cycles_reg <= filt_cycles(hv_cfg_reg[FILT_MSB:FILT_LSB]);
	end
	assign O_HV_FILT_CYCLES = hv_cycles_reg;
	assign O_HV_TRIP_KIND = hv_cfg_reg[KIND_MSB:KIND_LSB];
	assign O_HV_RANGE_HIGH = hv_range_reg[0];

	// ==========================================================================
	// auxiliary detector
	assign aux_bus.over_th = over_th_reg;
	assign aux_bus.under_th = under_th_reg;
	assign aux_bus.over_hyst = over_hy_reg[HYST_MSB:0];
	assign aux_bus.under_hyst = under_hy_reg[HYST_MSB:0];
	assign aux_bus.filt = aux_cfg_reg[FILT_MSB:FILT_LSB];
	assign aux_bus.kind = trip_kind_t'(aux_cfg_reg[KIND_MSB:KIND_LSB]);
	assign aux_bus.level = lvl_s2_reg;

	sfd_detector u_aux_det
	(
		.i_clk(I_REF_CLK),
		.i_rst_n(I_RST_N),
		.bus(aux_bus.det)
	);

	// ==========================================================================
	// pin function: fault and warning routing
	assign sfd_trip = aux_bus.high_trip || aux_bus.low_trip;

	always_comb
	begin
		fault_next = 1'b0;
		warn_next = 1'b0;
		case (pin_func_t'(aux_func_reg[1:0]))
			FUNC_SFD: fault_next = sfd_trip;
			FUNC_GPI: fault_next = pin_sync_reg[1];
			FUNC_GPI_WARN:
			begin
				fault_next = pin_sync_reg[1];
				warn_next = sfd_trip;
			end
			FUNC_NONE: fault_next = 1'b0;
			default: fault_next = 1'b0;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			fault_reg <= 1'b0;
			warn_reg <= 1'b0;
			trip_prev_reg <= 2'h0;
		end
		else
		begin
			fault_reg <= fault_next;
			warn_reg <= warn_next;
			trip_prev_reg <= {aux_bus.low_trip, aux_bus.high_trip};
		end
	end
	assign O_AUX1_FAULT = fault_reg;
	assign O_AUX1_WARN = warn_reg;

	// ==========================================================================
	// interrupts: sticky status, a new event beats a clear in the same cycle
	always_comb
	begin
		irq_set = '0;
		irq_set[IRQ_OVER] = aux_bus.high_trip && !trip_prev_reg[0];
		irq_set[IRQ_UNDER] = aux_bus.low_trip && !trip_prev_reg[1];
		irq_set[IRQ_FAULT] = fault_next && !fault_reg;
		irq_set[IRQ_WARN] = warn_next && !warn_reg;
		irq_clr = wr_hit(wr_en, idx, IDX_IRQ_CLEAR) ? I_PWDATA[IRQ_W-1:0] : '0;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			irq_status_reg <= '0;
			irq_en_reg <= '0;
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
			if (wr_hit(wr_en, idx, IDX_IRQ_ENABLE))
				irq_en_reg <= I_PWDATA[IRQ_W-1:0];
			irq_reg <= |(irq_status_reg & irq_en_reg);
		end
	end
	assign O_IRQ = irq_reg;

	// ==========================================================================
	// checks
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);
	AST_HV_FILT_MAX: assert property (hv_cfg_reg[FILT_MSB:FILT_LSB] == 3'h7
		|=> O_HV_FILT_CYCLES == 10'h3E8)
		else $error("longest filter code not 1000 cycles");
	AST_HV_FILT_MID: assert property (hv_cfg_reg[FILT_MSB:FILT_LSB] == 3'h6
		|=> O_HV_FILT_CYCLES == 10'h2EE)
		else $error("filter code six not 750 cycles");
	AST_HV_RANGE: assert property (wr_hit(wr_en, idx, IDX_HV_RANGE)
		|=> O_HV_RANGE_HIGH == $past(I_PWDATA[0]))
		else $error("range bit not taken from write");
	AST_FUNC_SFD: assert property (aux_func_reg[1:0] == 2'h0
		|=> O_AUX1_FAULT == $past(sfd_trip) && !O_AUX1_WARN)
		else $error("detector mode fault mismatch");
	// fault registered one edge after the mode it was computed in, pin two flops behind
	AST_FUNC_GPI: assert property (aux_func_reg[1:0] == 2'h1
		|=> O_AUX1_FAULT == $past(I_AUX1_PIN, 3))
		else $error("logic mode fault does not follow the pin");
	AST_FUNC_WARN: assert property (aux_func_reg[1:0] != 2'h2 |=> !O_AUX1_WARN)
		else $error("warning outside warning mode");
	AST_FUNC_NONE: assert property (aux_func_reg[1:0] == 2'h3 |=> !O_AUX1_FAULT)
		else $error("fault raised with no pin function");
	AST_RSVD_ZERO: assert property (pready_reg |-> O_PRDATA[31:8] == 24'h000000
		&& (idx != IDX_AUX_OVHY || O_PRDATA[7:5] == 3'h0))
		else $error("unused register bits read nonzero");
	COV_WARN_MODE: cover property (aux_func_reg[1:0] == 2'h2 ##1 O_AUX1_WARN);
	COV_IRQ: cover property ($rose(O_IRQ));
	COV_BAD_ADDR: cover property (O_PREADY && O_PSLVERR);
endmodule // sfd_cfg_bank
`default_nettype wire

// >>> rtl/sfd_cfg_pkg.sv
// Purpose: shared constants and types for the supply detector configuration bank
// Assumes: 10 MHz reference clock, 8-bit register contents on a 32-bit APB
// Notes: printed offsets are register indices, byte address is four times the index
`default_nettype none
package sfd_cfg_pkg;
	// ==========================================================================
	// bus and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int NS_PER_US = 1000;
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 9;
	// ==========================================================================
	// register indices
	localparam logic [7:0] IDX_HV_CFG = 8'h24;
	localparam logic [7:0] IDX_HV_RANGE = 8'h25;
	localparam logic [7:0] IDX_AUX_OVTH = 8'h28;
	localparam logic [7:0] IDX_AUX_OVHY = 8'h29;
	localparam logic [7:0] IDX_AUX_UVTH = 8'h2A;
	localparam logic [7:0] IDX_AUX_UVHY = 8'h2B;
	localparam logic [7:0] IDX_AUX_CFG = 8'h2C;
	localparam logic [7:0] IDX_AUX_FUNC = 8'h2D;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h41;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h42;
	localparam logic [7:0] IDX_AUX_LEVEL = 8'h43;
	// ==========================================================================
	// field layout, writable masks and reset values
	localparam int FILT_MSB = 4;
	localparam int FILT_LSB = 2;
	localparam int KIND_MSB = 1;
	localparam int KIND_LSB = 0;
	localparam int HYST_MSB = 4;
	localparam logic [7:0] MASK_CFG = 8'h1F;
	localparam logic [7:0] MASK_HYST = 8'h1F;
	localparam logic [7:0] MASK_RANGE = 8'h01;
	localparam logic [7:0] MASK_FUNC = 8'h03;
	localparam logic [7:0] RST_CFG = 8'h03;
	localparam logic [7:0] RST_FUNC = 8'h03;
	localparam logic [7:0] RST_OVTH = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam int IRQ_W = 4;
	localparam int IRQ_OVER = 0;
	localparam int IRQ_UNDER = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_WARN = 3;
	typedef enum logic [1:0] {KIND_OVER = 2'h0, KIND_BOTH = 2'h1, KIND_UNDER = 2'h2,
		KIND_OFF = 2'h3} trip_kind_t;
	typedef enum logic [1:0] {FUNC_SFD = 2'h0, FUNC_GPI = 2'h1, FUNC_GPI_WARN = 2'h2,
		FUNC_NONE = 2'h3} pin_func_t;
	// ==========================================================================
	// spike filter delays in microseconds, per code
	localparam int FILT_US [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
	function automatic logic [9:0] filt_cycles(input logic [2:0] code);
		int c;
		c = (FILT_US[code] * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return c[9:0];
	endfunction
	function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [4:0] b);
		logic [8:0] d;
		d = {1'b0, a} - {4'h0, b};
		return d[8] ? 8'h00 : d[7:0];
	endfunction
	function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [4:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {4'h0, b};
		return s[8] ? 8'hFF : s[7:0];
	endfunction
endpackage
`default_nettype wire

// >>> rtl/sfd_detector.sv
// Purpose: window comparison with hysteresis and spike filtering for one input
// Assumes: level is already synchronised to i_clk
// Notes: over trips when level exceeds the threshold, under when below it
`default_nettype none
module sfd_detector import sfd_cfg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	aux_det_if.det bus
);
	logic [7:0] eff_over;
	logic [7:0] eff_under;
	logic [9:0] limit;
	logic over_en;
	logic under_en;
	logic raw_over;
	logic raw_under;
	logic filt_over;
	logic filt_under;
	// ==========================================================================
	// effective thresholds and comparison
	always_comb
	begin
		limit = filt_cycles(bus.filt);
		over_en = (bus.kind == KIND_OVER) || (bus.kind == KIND_BOTH);
		under_en = (bus.kind == KIND_UNDER) || (bus.kind == KIND_BOTH);
		eff_over = bus.high_trip ? sat_sub(bus.over_th, bus.over_hyst) : bus.over_th;
		eff_under = bus.low_trip ? sat_add(bus.under_th, bus.under_hyst) : bus.under_th;
		raw_over = over_en && (bus.level > eff_over);
		raw_under = under_en && (bus.level < eff_under);
	end
	spike_filter u_over_filt
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_raw(raw_over),
		.i_limit(limit),
		.o_out(filt_over)
	);
	spike_filter u_under_filt
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_raw(raw_under),
		.i_limit(limit),
		.o_out(filt_under)
	);
	// gating after the filter makes a switch to off take effect at once
	assign bus.high_trip = filt_over && over_en;
	assign bus.low_trip = filt_under && under_en;
	// ==========================================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_KIND_OFF: assert property (bus.kind == KIND_OFF |-> !bus.high_trip && !bus.low_trip)
		else $error("detector trips while turned off");
	AST_OVER_CMP: assert property ($rose(bus.high_trip)
		|-> $past(bus.level) > $past(bus.over_th))
		else $error("over trip without level above threshold");
	AST_UNDER_CMP: assert property ($rose(bus.low_trip)
		|-> $past(bus.level) < $past(bus.under_th))
		else $error("under trip without level below threshold");
	AST_OVER_HYST: assert property (bus.high_trip && over_en
		&& bus.level > sat_sub(bus.over_th, bus.over_hyst) |=> bus.high_trip || $changed(bus.kind))
		else $error("over trip released inside hysteresis band");
	AST_UNDER_HYST: assert property (bus.low_trip && under_en
		&& bus.level < sat_add(bus.under_th, bus.under_hyst) |=> bus.low_trip || $changed(bus.kind))
		else $error("under trip released inside hysteresis band");
	COV_OVER_TRIP: cover property ($rose(bus.high_trip));
	COV_UNDER_TRIP: cover property ($rose(bus.low_trip));
endmodule // sfd_detector
`default_nettype wire

// >>> rtl/spike_filter.sv
// Purpose: ignore changes of a trip condition shorter than the selected delay
// Assumes: i_limit stable while a change is being timed
// Notes: a change must persist for limit plus one cycles
`default_nettype none
module spike_filter
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_raw,
	input wire logic [9:0] i_limit,
	output logic o_out
);
	logic [9:0] cnt_reg;
	logic out_reg;
	assign o_out = out_reg;
	// ==========================================================================
	// persistence counter
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_reg <= 10'h000;
			out_reg <= 1'b0;
		end
		else if (i_raw == out_reg)
			cnt_reg <= 10'h000;
		else if (cnt_reg >= i_limit)
		begin
			out_reg <= i_raw;
			cnt_reg <= 10'h000;
		end
		else
			cnt_reg <= cnt_reg + 10'h001;
	end
	// ==========================================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_FILT_HOLD: assert property ($changed(out_reg) |-> $past(cnt_reg) >= $past(i_limit))
		else $error("filter output changed before the delay ran out");
endmodule // spike_filter
`default_nettype wire
